// file: scan_pkg.sv
`default_nettype none
package scan_pkg;
  // channel count and converter word
  localparam int NCH   = 8;
  localparam int ADC_W = 24;

  // timing: times in their own unit, cycle counts derived from the clock
  localparam int CLK_NS       = 4;
  localparam int SLOT_MS      = 1;
  localparam int NORM_MS      = 9;
  localparam int FAST_BASE_MS = 1;
  localparam int FAST_CH_MS   = 1;
  localparam int SLOT_CYC     = SLOT_MS * 1000000 / CLK_NS;
  localparam int NORM_SLOTS   = NORM_MS / SLOT_MS;
  localparam int FAST_BASE_SL = FAST_BASE_MS / SLOT_MS;
  localparam int FAST_CH_SL   = FAST_CH_MS / SLOT_MS;

  // correction and scaling arithmetic
  localparam int GAIN_SH = 14;
  localparam logic signed [15:0] RECIP = 16'h1A37; // 2^26 / 10000
  localparam int SCL_SH = 26;
  localparam logic signed [16:0] BIP_OFS = 17'h02710;
  localparam logic [3:0] WDOG_SLOTS = 4'h4;
  localparam logic signed [15:0] WIRE_LIM = 16'hF8AD; // 1 mA on the live-zero scale

  typedef enum logic [2:0] {
    RNG_BIP10 = 3'h0, RNG_UNI10 = 3'h1, RNG_UNI5 = 3'h2,
    RNG_LIVE0 = 3'h3, RNG_BIP5  = 3'h4, RNG_USER = 3'h5
  } range_t;

  typedef enum logic [2:0] {
    AREA_NOM = 3'h0, AREA_LTOL = 3'h1, AREA_UTOL = 3'h2,
    AREA_UDF = 3'h3, AREA_OVF  = 3'h4
  } area_t;

  typedef enum logic [0:0] {ST_OVH = 1'b0, ST_CHAN = 1'b1} scan_st_t;

  // threshold limits and nominal span, indexed by range code
  localparam logic [15:0] UDF_MIN [6] =
    '{16'hD314, 16'hFA24, 16'hEC78, 16'hF060, 16'hC568, 16'h8000};
  localparam logic [15:0] UDF_MAX [6] =
    '{16'hD507, 16'hFC17, 16'hFC17, 16'hFCDF, 16'hD507, 16'h7FFF};
  localparam logic [15:0] OVF_MIN [6] =
    '{16'h2AF9, 16'h2AF9, 16'h2AF9, 16'h2A31, 16'h2AF9, 16'h8000};
  localparam logic [15:0] OVF_MAX [6] =
    '{16'h2C88, 16'h2C88, 16'h3A98, 16'h36B0, 16'h3A98, 16'h7FFF};
  localparam logic [15:0] NOM_LO [6] =
    '{16'hD8F0, 16'h0000, 16'h0000, 16'h0000, 16'hD8F0, 16'h0000};
  localparam logic [15:0] NOM_HI = 16'h2710;

  typedef struct packed {
    range_t            rng;
    logic              cur;
    logic              in_use;
    logic              lim_en;
    logic              user_bip;
    logic [2:0]        filt;
    logic signed [15:0] udf_thr;
    logic signed [15:0] ovf_thr;
    logic signed [15:0] user_lo;
    logic signed [15:0] user_hi;
    logic signed [15:0] align;
  } chan_cfg_t;

  typedef struct packed {
    area_t area;
    logic  wire_err;
    logic  conv_err;
  } chan_stat_t;

  typedef struct packed {
    logic wdog_err;
    logic chain_err;
  } mod_stat_t;

  typedef struct packed {
    logic [15:0]        gain;
    logic signed [15:0] offs;
    logic signed [15:0] drift;
  } cal_t;

  function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'sh7FFF) begin
      return 16'h7FFF;
    end else if (v < -48'sh8000) begin
      return 16'h8000;
    end
    return v[15:0];
  endfunction
endpackage
`default_nettype wire

// file: meas_filter.sv
`timescale 1ns/1ps
`default_nettype none
module meas_filter (
  input  wire logic signed [15:0] prev_i, // last filtered value
  input  wire logic signed [15:0] x_i,    // new corrected value
  input  wire logic [2:0]         lvl_i,  // filter level 0..6
  input  wire logic               seed_i, // no history yet
  output logic signed [15:0]      y_o     // filtered value
);
  logic signed [16:0] diff;
  logic signed [16:0] step;
  logic [2:0]         sh;

  // alpha = 1 - 2^-(lvl+1) for levels 1..6, level 0 passes the value through; levels above six act as six
  always_comb begin
    sh = (lvl_i > 3'h6) ? 3'h7 : lvl_i + 3'h1;
    diff = 17'(x_i) - 17'(prev_i);
    step = diff >>> sh;
    y_o = (lvl_i == 3'h0 || seed_i) ? x_i : prev_i + $signed(step[15:0]);
  end
endmodule
`default_nettype wire

// file: range_check.sv
`timescale 1ns/1ps
`default_nettype none
module range_check (
  input  wire logic signed [15:0] v_i,    // scaled measurement
  input  wire scan_pkg::chan_cfg_t cfg_i, // channel configuration
  output scan_pkg::area_t         area_o, // classification
  output logic                    wire_o  // broken wire seen
);
  scan_pkg::range_t   rc;
  logic signed [15:0] nlo;
  logic signed [15:0] nhi;
  logic signed [15:0] ut;
  logic signed [15:0] ot;

  // thresholds are clamped into the limits that the range allows
  always_comb begin
    rc = (cfg_i.rng > scan_pkg::RNG_USER) ? scan_pkg::RNG_BIP10 : cfg_i.rng;
    nlo = (rc == scan_pkg::RNG_USER) ? cfg_i.user_lo : $signed(scan_pkg::NOM_LO[rc]);
    nhi = (rc == scan_pkg::RNG_USER) ? cfg_i.user_hi : $signed(scan_pkg::NOM_HI);
    ut = cfg_i.udf_thr;
    if (ut < $signed(scan_pkg::UDF_MIN[rc])) ut = $signed(scan_pkg::UDF_MIN[rc]);
    if (ut > $signed(scan_pkg::UDF_MAX[rc])) ut = $signed(scan_pkg::UDF_MAX[rc]);
    ot = cfg_i.ovf_thr;
    if (ot < $signed(scan_pkg::OVF_MIN[rc])) ot = $signed(scan_pkg::OVF_MIN[rc]);
    if (ot > $signed(scan_pkg::OVF_MAX[rc])) ot = $signed(scan_pkg::OVF_MAX[rc]);
    // tolerance areas stay live even with the limit check off
    if (cfg_i.lim_en && v_i > ot) begin
      area_o = scan_pkg::AREA_OVF;
    end else if (v_i > nhi) begin
      area_o = scan_pkg::AREA_UTOL;
    end else if (cfg_i.lim_en && v_i < ut) begin
      area_o = scan_pkg::AREA_UDF;
    end else if (v_i < nlo) begin
      area_o = scan_pkg::AREA_LTOL;
    end else begin
      area_o = scan_pkg::AREA_NOM;
    end
    wire_o = (rc == scan_pkg::RNG_LIVE0) && (v_i < scan_pkg::WIRE_LIM);
  end
endmodule
`default_nettype wire

// file: ain_scan_top.sv
`timescale 1ns/1ps
`default_nettype none
module ain_scan_top #(
  parameter int SLOT_CYCLES = scan_pkg::SLOT_CYC // cycles per channel slot
) (
  input  wire logic                 mclk_i,                    // 250 MHz clock
  input  wire logic                 rst_n_i,                   // async reset, low
  input  wire logic                 fast_i,                    // fast cycle mode
  input  wire scan_pkg::chan_cfg_t  cfg_i [scan_pkg::NCH],     // channel setup
  input  wire scan_pkg::cal_t       cal_i,                     // self-cal terms
  input  wire logic                 adc_vld_i,                 // converter word valid
  input  wire logic [23:0]          adc_dat_i,                 // converter word
  output logic                      conv_start_o,              // slot start pulse
  output logic [2:0]                conv_ch_o,                 // mux channel
  output logic [1:0]                gain_o,                    // {bipolar, current}
  output logic signed [15:0]        meas_o [scan_pkg::NCH],    // latest values
  output scan_pkg::chan_stat_t      stat_o [scan_pkg::NCH],    // latest status
  output logic                      upd_o,                     // channel updated
  output logic [2:0]                upd_ch_o,                  // which channel
  output logic                      cyc_o,                     // scan cycle done
  output scan_pkg::mod_stat_t       mod_o                      // module status
);
  localparam int SW = $clog2(SLOT_CYCLES);

  scan_pkg::scan_st_t   st_q;
  logic [SW-1:0]        slot_q;
  logic [2:0]           ch_q;
  logic                 got_q;
  logic [scan_pkg::NCH-1:0] use_v;
  logic [scan_pkg::NCH-1:0] bip_v;
  logic                 slot_end;
  logic                 take;
  logic                 miss;
  logic [3:0]           nx;
  logic                 conv_start_q;
  logic [2:0]           conv_ch_q;
  logic [1:0]           gain_q;
  logic                 cyc_q;
  logic                 a_vld_q;
  logic [2:0]           a_ch_q;
  logic signed [15:0]   a_val_q;
  logic signed [32:0]   prod;
  logic signed [33:0]   corr;
  scan_pkg::chan_cfg_t  bc;
  logic signed [15:0]   fy;
  logic signed [16:0]   p2;
  logic signed [16:0]   span;
  logic signed [33:0]   sp;
  logic signed [47:0]   uq;
  logic signed [15:0]   sv;
  scan_pkg::area_t      area;
  logic                 wire_e;
  logic signed [15:0]   filt_q [scan_pkg::NCH];
  logic [scan_pkg::NCH-1:0] init_q;
  logic signed [15:0]   meas_q [scan_pkg::NCH];
  scan_pkg::chan_stat_t stat_q [scan_pkg::NCH];
  logic                 upd_q;
  logic [2:0]           upd_ch_q;
  logic [3:0]           wd_q;
  scan_pkg::mod_stat_t  mod_q;
  logic [4:0]           slots_q;
  logic                 mode_q;
  logic                 mix_q;

  // per-channel views of the configuration
  for (genvar i = 0; i < scan_pkg::NCH; i++) begin : g_ch
    assign use_v[i] = cfg_i[i].in_use;
    assign bip_v[i] = (cfg_i[i].rng == scan_pkg::RNG_BIP10) ||
                      (cfg_i[i].rng == scan_pkg::RNG_BIP5) ||
                      (cfg_i[i].rng == scan_pkg::RNG_USER && cfg_i[i].user_bip);
  end

  // lowest set mask bit at or above from; bit 3 set means none left
  function automatic logic [3:0] pick(input logic [3:0] from,
                                      input logic [scan_pkg::NCH-1:0] msk);
    logic [3:0] r;
    r = 4'h8;
    for (int i = scan_pkg::NCH - 1; i >= 0; i--) begin
      if (msk[i] && 4'(i) >= from) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  assign slot_end = slot_q == SW'(SLOT_CYCLES - 1);
  assign take = adc_vld_i && st_q == scan_pkg::ST_CHAN && !got_q;
  assign miss = slot_end && st_q == scan_pkg::ST_CHAN && !got_q && !adc_vld_i;

  // normal mode walks every channel, fast mode only the in-use ones
  always_comb begin
    nx = pick((st_q == scan_pkg::ST_OVH) ? 4'h0 : {1'b0, ch_q} + 4'h1,
              fast_i ? use_v : {scan_pkg::NCH{1'b1}});
  end

  // slot timer runs free of the controller, one slot per ms
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot_q <= '0;
    end else begin
      slot_q <= slot_end ? '0 : slot_q + 1'b1;
    end
  end

  // sequencer: one overhead slot, then a slot per scanned channel
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= scan_pkg::ST_OVH;
      ch_q <= 3'h0;
    end else if (slot_end) begin
      case (st_q)
        scan_pkg::ST_OVH, scan_pkg::ST_CHAN: begin
          if (nx[3]) begin
            st_q <= scan_pkg::ST_OVH;
          end else begin
            st_q <= scan_pkg::ST_CHAN;
            ch_q <= nx[2:0];
          end
        end
        default: begin
          st_q <= scan_pkg::ST_OVH;
        end
      endcase
    end
  end

  // only the first converter word of a slot counts
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      got_q <= 1'b0;
    end else begin
      got_q <= slot_end ? 1'b0 : (got_q | take);
    end
  end

  // mux, gain and start are set up for the slot that begins next
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_start_q <= 1'b0;
      conv_ch_q <= 3'h0;
      gain_q <= 2'h0;
      cyc_q <= 1'b0;
    end else begin
      conv_start_q <= slot_end && !nx[3];
      cyc_q <= slot_end && nx[3];
      if (slot_end && !nx[3]) begin
        conv_ch_q <= nx[2:0];
        gain_q <= {bip_v[nx[2:0]], cfg_i[nx[2:0]].cur};
      end
    end
  end

  // correction: self-cal gain and offset, drift, per-channel alignment
  always_comb begin
    prod = $signed(adc_dat_i[23:8]) * $signed({1'b0, cal_i.gain});
    corr = 34'(prod >>> scan_pkg::GAIN_SH) + 34'(cal_i.offs) - 34'(cal_i.drift)
         + 34'(cfg_i[ch_q].align);
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_vld_q <= 1'b0;
      a_ch_q <= 3'h0;
      a_val_q <= 16'h0000;
    end else begin
      a_vld_q <= take;
      if (take) begin
        a_ch_q <= ch_q;
        a_val_q <= scan_pkg::sat16(48'(corr));
      end
    end
  end

  assign bc = cfg_i[a_ch_q];

  // filter level is read live so it may change between samples
  meas_filter u_filt (
    .prev_i (filt_q[a_ch_q]),
    .x_i    (a_val_q),
    .lvl_i  (bc.filt),
    .seed_i (!init_q[a_ch_q]),
    .y_o    (fy)
  );

  // user scaling maps the standard 0..10000 span onto lo..hi; the
  // reciprocal multiply trades a divider for a tiny rounding error
  always_comb begin
    p2 = bc.user_bip ? (17'(fy) + scan_pkg::BIP_OFS) >>> 1 : 17'(fy);
    span = 17'(bc.user_hi) - 17'(bc.user_lo);
    sp = 34'(p2) * 34'(span);
    uq = (48'(sp) * 48'(scan_pkg::RECIP)) >>> scan_pkg::SCL_SH;
    sv = (bc.rng == scan_pkg::RNG_USER) ? scan_pkg::sat16(48'(bc.user_lo) + uq)
                                        : fy;
  end

  range_check u_chk (
    .v_i    (sv),
    .cfg_i  (bc),
    .area_o (area),
    .wire_o (wire_e)
  );

  // result table: value and status land in the same edge
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_q <= '0;
      for (int i = 0; i < scan_pkg::NCH; i++) begin
        filt_q[i] <= 16'h0000;
        meas_q[i] <= 16'h0000;
        stat_q[i] <= '0;
      end
    end else begin
      if (a_vld_q) begin
        filt_q[a_ch_q] <= fy;
        init_q[a_ch_q] <= 1'b1;
        meas_q[a_ch_q] <= sv;
        stat_q[a_ch_q] <= '{area: area, wire_err: wire_e, conv_err: 1'b0};
      end
      if (miss) begin
        stat_q[ch_q].conv_err <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upd_q <= 1'b0;
      upd_ch_q <= 3'h0;
    end else begin
      upd_q <= a_vld_q;
      upd_ch_q <= a_ch_q;
    end
  end

  // chain error follows the last slot; watchdog latches until reset
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wd_q <= 4'h0;
      mod_q <= '0;
    end else begin
      if (take) begin
        wd_q <= 4'h0;
        mod_q.chain_err <= 1'b0;
      end else if (miss) begin
        mod_q.chain_err <= 1'b1;
        if (wd_q != scan_pkg::WDOG_SLOTS) begin
          wd_q <= wd_q + 4'h1;
        end
      end
      if (wd_q == scan_pkg::WDOG_SLOTS) begin
        mod_q.wdog_err <= 1'b1;
      end
    end
  end

  // outputs straight from flops; the controller samples them freely
  assign conv_start_o = conv_start_q;
  assign conv_ch_o = conv_ch_q;
  assign gain_o = gain_q;
  assign meas_o = meas_q;
  assign stat_o = stat_q;
  assign upd_o = upd_q;
  assign upd_ch_o = upd_ch_q;
  assign cyc_o = cyc_q;
  assign mod_o = mod_q;

  // checking helpers: slots per cycle and whether the mode moved
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slots_q <= 5'h00;
      mode_q <= 1'b0;
      mix_q <= 1'b0;
    end else if (slot_end) begin
      if (nx[3]) begin
        slots_q <= 5'h00;
        mode_q <= fast_i;
        mix_q <= 1'b0;
      end else begin
        slots_q <= slots_q + 5'h01;
        mix_q <= mix_q | (fast_i != mode_q);
      end
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_take;
    take;
  endsequence

  sequence s_publish;
    ##1 a_vld_q ##1 upd_q;
  endsequence

  AST_NORM_SLOTS:
  assert property (slot_end && nx[3] && !fast_i && !mode_q && !mix_q
                   |-> 32'(slots_q) == scan_pkg::NORM_SLOTS - 1)
    else $error("normal scan cycle has wrong slot count");

  AST_FAST_SLOTS:
  assert property (slot_end && nx[3] && fast_i && mode_q && !mix_q
                   |-> 32'(slots_q) + 1 == scan_pkg::FAST_BASE_SL
                       + scan_pkg::FAST_CH_SL * $countones(use_v))
    else $error("fast scan cycle has wrong slot count");

  AST_FAST_INUSE:
  assert property (conv_start_o && $past(fast_i) |-> |($past(use_v) & (8'h01 << conv_ch_o)))
    else $error("fast cycle scanned a channel not in use");

  AST_TAKE_TO_UPD:
  assert property (s_take |-> s_publish)
    else $error("captured result not published two cycles later");

  AST_GAIN_SEL:
  assert property (slot_end && !nx[3]
                   |=> conv_start_o && conv_ch_o == $past(nx[2:0])
                       && gain_o == $past({bip_v[nx[2:0]], cfg_i[nx[2:0]].cur}))
    else $error("gain select does not match channel range");

  AST_FILT_BYPASS:
  assert property (upd_o && $past(bc.filt == 3'h0 && bc.rng != scan_pkg::RNG_USER)
                   |-> meas_o[upd_ch_o] == $past(a_val_q))
    else $error("level zero filter altered the value");

  AST_TOL_ALWAYS:
  assert property (upd_o && $past(!bc.lim_en) && meas_o[upd_ch_o] > $past(sv) - 16'h0001
                   && $past(sv > 16'sh2710 && bc.rng != scan_pkg::RNG_USER)
                   |-> stat_o[upd_ch_o].area == scan_pkg::AREA_UTOL)
    else $error("upper tolerance missed with limit check off");

  AST_NOM_UNI10:
  assert property (upd_o && $past(bc.rng == scan_pkg::RNG_UNI10)
                   && stat_o[upd_ch_o].area == scan_pkg::AREA_NOM
                   |-> meas_o[upd_ch_o] >= 16'sh0000 && meas_o[upd_ch_o] <= 16'sh2710)
    else $error("nominal area outside 0..10000");

  AST_OVF_HARD:
  assert property (upd_o && $past(bc.lim_en && bc.rng != scan_pkg::RNG_USER)
                   && meas_o[upd_ch_o] > 16'sh3A98
                   |-> stat_o[upd_ch_o].area == scan_pkg::AREA_OVF)
    else $error("value above every overflow limit not flagged");

  AST_WIRE_ERR:
  assert property (upd_o && $past(bc.rng == scan_pkg::RNG_LIVE0)
                   && meas_o[upd_ch_o] < scan_pkg::WIRE_LIM
                   |-> stat_o[upd_ch_o].wire_err)
    else $error("open live-zero input not flagged");

  AST_MISS_FLAG:
  assert property (miss |=> stat_o[$past(ch_q)].conv_err && mod_o.chain_err)
    else $error("missing converter word not reported");
endmodule
`default_nettype wire

// file: conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module conv_model (
  input  wire logic        mclk_i,  // block clock
  input  wire logic        start_i, // slot start from the block
  input  wire logic [15:0] val_i,   // value to hand back
  input  wire logic [3:0]  dly_i,   // answer delay, 1..12 cycles
  input  wire logic        skip_i,  // leave this slot unanswered
  output logic             vld_o,   // word valid
  output logic [23:0]      dat_o    // converter word
);
  int cnt;

  initial begin
    cnt = 0;
    vld_o = 1'b0;
    dat_o = 24'h000000;
  end

  // one word per started slot after the asked delay; idle data toggles so stale bits never match
  always @(posedge mclk_i) begin
    vld_o <= 1'b0;
    dat_o <= ~dat_o;
    if (start_i) begin
      cnt <= skip_i ? 0 : int'(dly_i);
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      vld_o <= 1'b1;
      dat_o <= {val_i, 8'($urandom)};
    end
  end
endmodule
`default_nettype wire

// file: eight_channel_input_scan_range_check_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eight_channel_input_scan_range_check_tb;
  localparam int S = 16;
  localparam int N = scan_pkg::NCH;
  logic                 mclk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 fast = 1'b0;
  scan_pkg::chan_cfg_t  cfg [N];
  scan_pkg::cal_t       cal;
  logic                 vld;
  logic [23:0]          dat;
  logic                 start;
  logic [2:0]           ch;
  logic [1:0]           gain;
  logic signed [15:0]   meas [N];
  scan_pkg::chan_stat_t stat [N];
  logic                 upd;
  logic                 cyc;
  logic [2:0]           uch;
  scan_pkg::mod_stat_t  mods;
  logic [15:0]          val = 16'h0000;
  logic [3:0]           dly = 4'h3;
  logic                 skip = 1'b0;
  int                   n_fail = 0;
  int                   checked = 0;
  logic [22:0]          expq [$];
  int                   prev [N];
  bit                   seeded [N];
  int                   last_ch = -1;
  int                   cyc_len = 0;
  int                   cyc_skip = 1;
  int                   udf_t [6] = '{-11200, -1200, -3000, -900, -13000, -20000};
  int                   ovf_t [6] = '{11200, 11200, 13000, 12000, 13000, 20000};

  ain_scan_top #(.SLOT_CYCLES(S)) dut_u (
    .mclk_i(mclk), .rst_n_i(rst_n), .fast_i(fast), .cfg_i(cfg), .cal_i(cal),
    .adc_vld_i(vld), .adc_dat_i(dat), .conv_start_o(start), .conv_ch_o(ch),
    .gain_o(gain), .meas_o(meas), .stat_o(stat), .upd_o(upd), .upd_ch_o(uch),
    .cyc_o(cyc), .mod_o(mods));

  conv_model conv_u (
    .mclk_i(mclk), .start_i(start), .val_i(val), .dly_i(dly), .skip_i(skip),
    .vld_o(vld), .dat_o(dat));

  // 250 MHz clock
  initial begin
    forever #2 mclk = ~mclk;
  end

  task automatic check(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // correction, filter and user scale on the raw word, history kept per channel
  function automatic int exp_val(int c, int raw);
    int x;
    int y;
    int l;
    int p;
    x = ((raw * int'(cal.gain)) >>> 14) + cal.offs - cal.drift + cfg[c].align;
    l = (cfg[c].filt > 6) ? 6 : int'(cfg[c].filt);
    y = (l == 0 || !seeded[c]) ? x : prev[c] + ((x - prev[c]) >>> (l + 1));
    prev[c] = y;
    seeded[c] = 1'b1;
    if (cfg[c].rng != scan_pkg::RNG_USER) return y;
    p = cfg[c].user_bip ? (y + 10000) >>> 1 : y;
    return cfg[c].user_lo + int'((longint'(p) * (cfg[c].user_hi - cfg[c].user_lo) * 6711) >>> 26);
  endfunction

  function automatic scan_pkg::area_t exp_area(int v, scan_pkg::chan_cfg_t c);
    int lo;
    int hi;
    lo = (c.rng == scan_pkg::RNG_BIP10 || c.rng == scan_pkg::RNG_BIP5) ? -10000 : 0;
    lo = (c.rng == scan_pkg::RNG_USER) ? int'(c.user_lo) : lo;
    hi = (c.rng == scan_pkg::RNG_USER) ? int'(c.user_hi) : 10000;
    if (c.lim_en && v > c.ovf_thr) return scan_pkg::AREA_OVF;
    if (v > hi) return scan_pkg::AREA_UTOL;
    if (c.lim_en && v < c.udf_thr) return scan_pkg::AREA_UDF;
    if (v < lo) return scan_pkg::AREA_LTOL;
    return scan_pkg::AREA_NOM;
  endfunction

  // per test: mode, limit checking, in-use mask and filter choice; applied at a cycle end
  task automatic setup(bit f, bit lim, logic [7:0] use_m, bit rnd_filt);
    fast <= f;
    dly <= 4'($urandom_range(12, 1));
    for (int i = 0; i < N; i++) begin
      cfg[i].rng <= scan_pkg::range_t'(i % 6);
      cfg[i].cur <= 1'($urandom);
      cfg[i].in_use <= use_m[i];
      cfg[i].lim_en <= lim;
      cfg[i].user_bip <= 1'($urandom);
      cfg[i].filt <= rnd_filt ? 3'($urandom) : 3'h0;
      cfg[i].udf_thr <= 16'(udf_t[i % 6]);
      cfg[i].ovf_thr <= 16'(ovf_t[i % 6]);
      cfg[i].user_lo <= 16'h0C80;
      cfg[i].user_hi <= 16'h2580;
      cfg[i].align <= 16'(int'($urandom_range(2000)) - 1000);
    end
  endtask

  task automatic wait_cyc(int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge mclk);
        k++;
      end while (!cyc && k < 20 * S);
      if (k >= 20 * S) check(32'h0, 32'h1);
    end
  endtask

  // driver side: answer value per slot start, expectation noted in the queue
  always @(posedge mclk) begin
    int e;
    int r;
    int v;
    int nu;
    cyc_len++;
    if (rst_n && cyc) begin
      nu = 0;
      for (int i = 0; i < N; i++) nu += (fast ? int'(cfg[i].in_use) : 1);
      if (cyc_skip == 0) check(cyc_len, S * (1 + nu));
      cyc_skip = 0;
      cyc_len = 0;
      last_ch = -1;
    end
    if (rst_n && start) begin
      e = last_ch + 1;
      while (fast && e < N && !cfg[e].in_use) e++;
      check(ch, e);
      check(gain, {cfg[ch].rng == scan_pkg::RNG_BIP10 || cfg[ch].rng == scan_pkg::RNG_BIP5 ||
                   (cfg[ch].rng == scan_pkg::RNG_USER && cfg[ch].user_bip),
                   cfg[ch].cur});
      last_ch = ch;
      r = int'($urandom_range(22000)) - 11000;
      val <= r[15:0];
      if (!skip) begin
        v = exp_val(ch, r);
        expq.push_back({ch, 16'(v), exp_area(v, cfg[ch]),
                        cfg[ch].rng == scan_pkg::RNG_LIVE0 && v < -1875});
      end
    end
  end

  // monitor: oldest expectation against each published update
  always @(posedge mclk) begin
    logic [22:0] q;
    if (rst_n && upd) begin
      q = (expq.size() > 0) ? expq.pop_front() : 23'h7FFFFF;
      check({uch, meas[uch], stat[uch].area, stat[uch].wire_err, stat[uch].conv_err},
            {q, 1'b0});
    end
  end

  // watchdog on a hung run
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end

  initial begin
    void'($urandom(32'hBB7D));
    cal = '{gain: 16'h4000, offs: 16'sh0007, drift: 16'sh0003};
    for (int i = 0; i < N; i++) cfg[i] = '0;
    repeat (16) @(posedge mclk);
    setup(1'b0, 1'b1, 8'hFF, 1'b0);
    rst_n <= 1'b1;
    wait_cyc(3);
    $display("test 1 done");
    setup(1'b0, 1'b0, 8'hFF, 1'b1);
    wait_cyc(3);
    $display("test 2 done");
    setup(1'b1, 1'b1, 8'($urandom_range(255, 1)), 1'b1);
    // gain of 1.5 drives values past the overflow limit of every range except the user one
    cal.gain <= 16'h6000;
    wait_cyc(3);
    $display("test 3 done");
    setup(1'b1, 1'b1, 8'h00, 1'b0);
    wait_cyc(2);
    $display("test 4 done");
    setup(1'b0, 1'b1, 8'hFF, 1'b0);
    skip <= 1'b1;
    wait_cyc(1);
    check({mods.wdog_err, mods.chain_err, stat[7].conv_err}, 3'h7);
    skip <= 1'b0;
    wait_cyc(1);
    check({mods.wdog_err, mods.chain_err, stat[7].conv_err}, 3'h4);
    $display("test 5 done");
    end_sim();
  end
endmodule
`default_nettype wire
